// ==== design/tst_pkg.sv ====
// constants, types and register map of the temperature trim and reset block
package tst_pkg;
  localparam logic [7:0] PTR_LOC_HI  = 8'h00;
  localparam logic [7:0] PTR_REM_HI  = 8'h01;
  localparam logic [7:0] PTR_STATUS  = 8'h02;
  localparam logic [7:0] PTR_CFG_RD  = 8'h03;
  localparam logic [7:0] PTR_CFG_WR  = 8'h09;
  localparam logic [7:0] PTR_ONESHOT = 8'h0f;
  localparam logic [7:0] PTR_REM_LO  = 8'h10;
  localparam logic [7:0] PTR_OFFS_HI = 8'h11;
  localparam logic [7:0] PTR_OFFS_LO = 8'h12;
  localparam logic [7:0] PTR_LOC_LO  = 8'h15;
  localparam logic [7:0] PTR_IDEAL   = 8'h23;
  localparam logic [7:0] PTR_MAKER   = 8'hfe;

  localparam logic [7:0] GC_RESET_CMD = 8'h06;

  localparam logic [7:0]  CFG_RST   = 8'h00;
  localparam logic [7:0]  CFG_WMASK = 8'he4;
  localparam int          CFG_STOP_BIT = 6;
  localparam int          STAT_BUSY_BIT = 7;
  localparam logic [7:0]  IDEAL_RST = 8'h00;
  localparam logic [15:0] OFFS_RST  = 16'h0000;
  localparam logic [15:0] RES_RST   = 16'h0000;
  localparam logic [7:0]  LO_MASK   = 8'hf0;

  localparam logic [12:0] ETA_BASE  = 13'h0828;
  localparam int          NUM_W     = 28;
  localparam logic [4:0]  DIV_STEPS = 5'h1c;

  localparam int CLK_MHZ = 250;
  localparam int GAP_NS  = 1000;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ) / 1000;
  localparam logic [8:0] GAP_LAST = 9'(GAP_CYC - 1);

  typedef struct packed {
    logic       en;
    logic [7:0] ptr;
    logic [7:0] data;
  } tst_wr_t;

  typedef struct packed {
    logic       en;
    logic [7:0] ptr;
  } tst_rd_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_LOC  = 5'b00010,
    S_REM  = 5'b00100,
    S_CORR = 5'b01000,
    S_GAP  = 5'b10000
  } tst_state_t;
endpackage

// ==== design/tst_ideal_div.sv ====
// remote code scaling by the ideality adjust, serial restoring divider
`timescale 1ns/1ps
module tst_ideal_div (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire logic [15:0] code,
  input  wire logic [7:0]  adj,
  output logic             done,
  output logic [15:0]      result
);
  import tst_pkg::*;

  logic             busy_q, busy_d;
  logic [4:0]       cnt_q, cnt_d;
  logic [NUM_W-1:0] num_q, num_d;
  logic [NUM_W-1:0] quo_q, quo_d;
  logic [12:0]      rem_q, rem_d;
  logic [12:0]      den_q, den_d;
  logic             done_q, done_d;
  logic [15:0]      res_q, res_d;
  logic [13:0]      rem_sh;
  logic [NUM_W-1:0] quo_nx;

  // q = code * 2088 / (2088 + adj); adj is signed so the divisor stays 1960..2215
  always_comb begin
    busy_d = busy_q;
    cnt_d  = cnt_q;
    num_d  = num_q;
    quo_d  = quo_q;
    rem_d  = rem_q;
    den_d  = den_q;
    done_d = 1'b0;
    res_d  = res_q;
    rem_sh = {rem_q, num_q[NUM_W-1]};
    quo_nx = {quo_q[NUM_W-2:0], 1'b0};
    if (start && !busy_q) begin
      busy_d = 1'b1;
      cnt_d  = '0;
      rem_d  = '0;
      quo_d  = '0;
      num_d  = NUM_W'({12'h000, code} * {15'h0000, ETA_BASE});
      den_d  = ETA_BASE + {{5{adj[7]}}, adj};
    end else if (busy_q) begin
      num_d = {num_q[NUM_W-2:0], 1'b0};
      if (rem_sh >= {1'b0, den_q}) begin
        rem_d  = 13'(rem_sh - {1'b0, den_q});
        quo_nx = quo_nx | NUM_W'(1);
      end else begin
        rem_d = rem_sh[12:0];
      end
      quo_d = quo_nx;
      cnt_d = cnt_q + 5'h01;
      if (cnt_q == DIV_STEPS - 5'h01) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        // a negative adjust can push the code past full scale: clamp it
        res_d  = (|quo_nx[NUM_W-1:16]) ? 16'hffff : quo_nx[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
      num_q  <= '0;
      quo_q  <= '0;
      rem_q  <= '0;
      den_q  <= '0;
      done_q <= 1'b0;
      res_q  <= RES_RST;
    end else begin
      busy_q <= busy_d;
      cnt_q  <= cnt_d;
      num_q  <= num_d;
      quo_q  <= quo_d;
      rem_q  <= rem_d;
      den_q  <= den_d;
      done_q <= done_d;
      res_q  <= res_d;
    end
  end

  assign done   = done_q;
  assign result = res_q;
endmodule

// ==== design/tst_offset_add.sv ====
// adds the signed offset to a result code with clamping at both ends
`timescale 1ns/1ps
module tst_offset_add (
  input  wire logic [15:0] code,
  input  wire logic [15:0] offset,
  output logic [15:0]      sum
);
  logic [17:0] wide;

  // offset shares the result encoding, so it adds straight on
  always_comb begin
    wide = {2'b00, code} + {{2{offset[15]}}, offset};
    if (wide[17]) begin
      sum = 16'h0000;
    end else if (wide[16]) begin
      sum = 16'hffff;
    end else begin
      sum = wide[15:0];
    end
  end
endmodule

// ==== design/tst_core.sv ====
// conversion sequencer, trim registers and general call reset of the sensor
`timescale 1ns/1ps
module tst_core #(
  parameter logic [7:0] MAKER_ID = 8'h5a // arbitrary value
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire tst_pkg::tst_wr_t wr,
  input  wire tst_pkg::tst_rd_t rd,
  output logic [7:0]            rdata,
  input  wire logic             gc_valid,
  input  wire logic [7:0]       gc_byte,
  output logic                  gc_ack,
  output logic                  adc_start,
  output logic                  adc_remote,
  output logic                  adc_abort,
  input  wire logic             adc_done,
  input  wire logic [15:0]      adc_code,
  output logic                  busy
);
  import tst_pkg::*;

  logic        srst;
  logic        soft_q, soft_d;
  tst_state_t  state_q, state_d;
  logic [8:0]  gap_q, gap_d;
  logic        start_q, start_d;
  logic        sel_q, sel_d;
  logic [7:0]  cfg_q, cfg_d;
  logic [7:0]  ideal_q, ideal_d;
  logic [15:0] offs_q, offs_d;
  logic [15:0] loc_q, loc_d;
  logic [15:0] rem_q, rem_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        stop;
  logic        oneshot;
  logic        div_start;
  logic        div_done;
  logic [15:0] div_res;
  logic [15:0] rem_sum;

  assign srst    = rst | soft_q;
  assign stop    = cfg_q[CFG_STOP_BIT];
  // the trigger is a pure strobe: its data byte is never looked at
  assign oneshot = wr.en && (wr.ptr == PTR_ONESHOT);
  assign gc_ack  = gc_valid;

  // software reset is taken one cycle after the command byte, then acts
  // as a full synchronous reset for everything except itself
  always_comb begin
    soft_d = gc_valid && (gc_byte == GC_RESET_CMD);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= soft_d;
    end
  end

  tst_ideal_div u_div (
    .clk    (clk),
    .srst   (srst),
    .start  (div_start),
    .code   (adc_code),
    .adj    (ideal_q),
    .done   (div_done),
    .result (div_res)
  );

  tst_offset_add u_offs (
    .code   (div_res),
    .offset (offs_q),
    .sum    (rem_sum)
  );

  // sequencer
  always_comb begin
    state_d   = state_q;
    gap_d     = gap_q;
    start_d   = 1'b0;
    sel_d     = sel_q;
    div_start = 1'b0;
    loc_d     = loc_q;
    rem_d     = rem_q;
    case (state_q)
      S_IDLE: begin
        // a trigger is only honoured when fully stopped; while running it
        // is simply dropped so the schedule does not shift
        if (!stop || oneshot) begin
          start_d = 1'b1;
          sel_d   = 1'b0;
          state_d = S_LOC;
        end
      end
      S_LOC: begin
        if (adc_done) begin
          loc_d   = adc_code;
          start_d = 1'b1;
          sel_d   = 1'b1;
          state_d = S_REM;
        end
      end
      S_REM: begin
        if (adc_done) begin
          div_start = 1'b1;
          state_d   = S_CORR;
        end
      end
      S_CORR: begin
        if (div_done) begin
          rem_d = rem_sum;
          gap_d = '0;
          // once a sequence has started, stop is looked at only here, so a sequence under way always ends
          state_d = stop ? S_IDLE : S_GAP;
        end
      end
      S_GAP: begin
        gap_d = gap_q + 9'h001;
        if (gap_q == GAP_LAST) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // register file
  always_comb begin
    cfg_d   = cfg_q;
    ideal_d = ideal_q;
    offs_d  = offs_q;
    rdata_d = rdata_q;
    if (wr.en) begin
      case (wr.ptr)
        PTR_CFG_WR:  cfg_d = wr.data & CFG_WMASK;
        PTR_IDEAL:   ideal_d = wr.data;
        PTR_OFFS_HI: offs_d[15:8] = wr.data;
        PTR_OFFS_LO: offs_d[7:0] = wr.data & LO_MASK;
        default:     cfg_d = cfg_q;
      endcase
    end
    if (rd.en) begin
      case (rd.ptr)
        PTR_LOC_HI:  rdata_d = loc_q[15:8];
        PTR_LOC_LO:  rdata_d = loc_q[7:0] & LO_MASK;
        PTR_REM_HI:  rdata_d = rem_q[15:8];
        PTR_REM_LO:  rdata_d = rem_q[7:0] & LO_MASK;
        PTR_STATUS:  rdata_d = {busy, 7'h00};
        PTR_CFG_RD:  rdata_d = cfg_q;
        PTR_IDEAL:   rdata_d = ideal_q;
        PTR_OFFS_HI: rdata_d = offs_q[15:8];
        PTR_OFFS_LO: rdata_d = offs_q[7:0];
        PTR_MAKER:   rdata_d = MAKER_ID;
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  // one reset path for power-on and software reset; results are reset
  // too, so an aborted conversion can never land
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      gap_q   <= '0;
      start_q <= 1'b0;
      sel_q   <= 1'b0;
      cfg_q   <= CFG_RST;
      ideal_q <= IDEAL_RST;
      offs_q  <= OFFS_RST;
      loc_q   <= RES_RST;
      rem_q   <= RES_RST;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      gap_q   <= gap_d;
      start_q <= start_d;
      sel_q   <= sel_d;
      cfg_q   <= cfg_d;
      ideal_q <= ideal_d;
      offs_q  <= offs_d;
      loc_q   <= loc_d;
      rem_q   <= rem_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata      = rdata_q;
  assign adc_start  = start_q;
  assign adc_remote = sel_q;
  assign adc_abort  = soft_q;
  assign busy       = (state_q != S_IDLE) && (state_q != S_GAP);

  property p_oneshot_start;
    @(posedge clk) disable iff (srst)
    (state_q == S_IDLE && stop && oneshot) |=> (adc_start && !adc_remote);
  endproperty
  a_oneshot_start: assert property (p_oneshot_start)
    else $error("trigger in shutdown did not start a local conversion");

  property p_remote_follows;
    @(posedge clk) disable iff (srst)
    (state_q == S_LOC && adc_done) |=> (adc_start && adc_remote) ##1 (state_q == S_REM);
  endproperty
  a_remote_follows: assert property (p_remote_follows)
    else $error("remote conversion did not follow the local one");

  property p_stay_shutdown;
    @(posedge clk) disable iff (srst)
    (state_q == S_CORR && div_done && stop) ##1 (!oneshot && stop)
      |=> (!adc_start && state_q == S_IDLE);
  endproperty
  a_stay_shutdown: assert property (p_stay_shutdown)
    else $error("conversion started again after the triggered cycle");

  property p_ideal_por;
    @(posedge clk)
    rst |=> (ideal_q == IDEAL_RST);
  endproperty
  a_ideal_por: assert property (p_ideal_por)
    else $error("adjust register not cleared by reset");

  property p_ideal_rw;
    @(posedge clk) disable iff (srst)
    (wr.en && wr.ptr == PTR_IDEAL) |=> (ideal_q == $past(wr.data));
  endproperty
  a_ideal_rw: assert property (p_ideal_rw)
    else $error("adjust register did not take the written value");

  property p_offset_add;
    @(posedge clk) disable iff (srst)
    (state_q == S_CORR && div_done) |=> (rem_q == $past(rem_sum));
  endproperty
  a_offset_add: assert property (p_offset_add)
    else $error("remote result not stored with the offset added");

  property p_gc_ack;
    @(posedge clk) disable iff (rst)
    gc_valid |-> gc_ack;
  endproperty
  a_gc_ack: assert property (p_gc_ack)
    else $error("general call not acknowledged");

  property p_soft_reset;
    @(posedge clk) disable iff (rst)
    (gc_valid && gc_byte == GC_RESET_CMD)
      |-> ##2 (state_q == S_IDLE && cfg_q == CFG_RST && ideal_q == IDEAL_RST
               && offs_q == OFFS_RST && rem_q == RES_RST && !adc_start);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset did not restore the power-on state");

  property p_gc_other;
    @(posedge clk) disable iff (rst)
    (gc_valid && gc_byte != GC_RESET_CMD) |=> !soft_q;
  endproperty
  a_gc_other: assert property (p_gc_other)
    else $error("non-reset general call byte caused a reset");

  property p_maker_id;
    @(posedge clk) disable iff (srst)
    (rd.en && rd.ptr == PTR_MAKER) |=> (rdata == MAKER_ID);
  endproperty
  a_maker_id: assert property (p_maker_id)
    else $error("maker code read returned a wrong value");

  property p_run_ignores_trigger;
    @(posedge clk) disable iff (srst)
    (state_q == S_GAP && gap_q != GAP_LAST && oneshot) |=> (state_q == S_GAP);
  endproperty
  a_run_ignores_trigger: assert property (p_run_ignores_trigger)
    else $error("trigger write disturbed the continuous schedule");
endmodule

// ==== test/tst_adc_model.sv ====
// behavioural converter on the far side of the sequencer
`timescale 1ns/1ps
module tst_adc_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        adc_start,
  input  wire logic        adc_remote,
  input  wire logic        adc_abort,
  input  wire logic [7:0]  lat,
  input  wire logic [15:0] code_loc,
  input  wire logic [15:0] code_rem,
  output logic             adc_done,
  output logic [15:0]      adc_code
);
  int   cnt_q;
  logic rem_q;
  initial adc_code = 16'ha5a5;
  always @(posedge clk) begin
    adc_done <= 1'b0;
    // between results the code toggles so a stale sample never looks valid
    adc_code <= ~adc_code;
    if (rst || adc_abort) begin
      cnt_q <= 0;
    end else if (adc_start) begin
      cnt_q <= lat + 1;
      rem_q <= adc_remote;
    end else if (cnt_q == 1) begin
      cnt_q    <= 0;
      adc_done <= 1'b1;
      adc_code <= rem_q ? code_rem : code_loc;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule

// ==== test/tb_top.sv ====
// self-checking bench of the trim and reset block
`timescale 1ns/1ps
module tb_top;
  import tst_pkg::*;
  localparam logic [7:0] TB_MAKER = 8'h3c; // arbitrary value
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  tst_wr_t     wr = '0;
  tst_rd_t     rd = '0;
  logic [7:0]  rdata;
  logic        gc_valid = 1'b0;
  logic [7:0]  gc_byte = 8'h00;
  logic        gc_ack, adc_start, adc_remote, adc_abort, adc_done, busy;
  logic [15:0] adc_code;
  logic [7:0]  lat = 8'h03;
  logic [15:0] code_loc = 16'h0000;
  logic [15:0] code_rem = 16'h0000;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          n_start = 0;
  int          n_rem = 0;
  int          n_abort = 0;

  always #2 clk = ~clk;

  tst_core #(.MAKER_ID(TB_MAKER)) u_tst_core (
    .clk(clk), .rst(rst), .wr(wr), .rd(rd), .rdata(rdata), .gc_valid(gc_valid),
    .gc_byte(gc_byte), .gc_ack(gc_ack), .adc_start(adc_start), .adc_remote(adc_remote),
    .adc_abort(adc_abort), .adc_done(adc_done), .adc_code(adc_code), .busy(busy)
  );
  tst_adc_model u_tst_adc_model (
    .clk(clk), .rst(rst), .adc_start(adc_start), .adc_remote(adc_remote),
    .adc_abort(adc_abort), .lat(lat), .code_loc(code_loc), .code_rem(code_rem),
    .adc_done(adc_done), .adc_code(adc_code)
  );

  always @(posedge clk) begin
    if (adc_start === 1'b1) begin
      n_start++;
      if (adc_remote === 1'b1) n_rem++;
    end
    if (adc_abort === 1'b1) n_abort++;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_reg(string what, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_num(string what, int e, int g);
    samples_checked++;
    if (g != e) begin
      error_cnt++;
      $display("mismatch %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic wr_reg(logic [7:0] p, logic [7:0] d);
    @(posedge clk);
    wr <= '{1'b1, p, d};
    @(posedge clk);
    wr <= '0;
  endtask

  task automatic rd_reg(logic [7:0] p, output logic [7:0] d);
    @(posedge clk);
    rd <= '{1'b1, p};
    @(posedge clk);
    rd <= '0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(string what, logic [7:0] p, logic [7:0] e);
    logic [7:0] d;
    rd_reg(p, d);
    chk_reg(what, e, d);
  endtask

  task automatic gen_call(logic [7:0] b);
    @(posedge clk);
    gc_valid <= 1'b1;
    gc_byte  <= b;
    @(posedge clk);
    chk_reg("gc_ack", 8'h01, {7'h00, gc_ack});
    gc_valid <= 1'b0;
  endtask

  task automatic wait_idle();
    int k;
    repeat (3) @(posedge clk);
    #1;
    // look after the edge so busy shows the state that edge produced
    for (k = 0; k < 5000 && busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    if (busy !== 1'b0) begin
      error_cnt++;
      $display("mismatch busy expected 0 seen %b", busy);
    end
  endtask

  // remote result: ideality scaling, clamp, then signed offset with clamp
  function automatic logic [15:0] exp_rem(int c, logic [7:0] a, logic [15:0] o);
    int q;
    q = c * 2088 / (2088 + $signed(a));
    if (q > 65535) q = 65535;
    q = q + $signed(o);
    if (q < 0) q = 0;
    if (q > 65535) q = 65535;
    return q[15:0];
  endfunction

  initial begin
    // roughly four times the expected length of the whole run
    #60000;
    error_cnt++;
    $display("mismatch watchdog expected done seen hang");
    give_verdict();
  end

  logic [7:0]  adj_tab [6] = '{8'h00, 8'h7f, 8'h80, 8'h0a, 8'hf6, 8'h00};
  logic [7:0]  adj;
  logic [15:0] off, er;
  int          i;

  initial begin
    void'($urandom(12116));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ideal_rst", PTR_IDEAL, 8'h00);
    rd_chk("maker", PTR_MAKER, TB_MAKER);
    rd_chk("unmapped", 8'h77, 8'h00);
    wr_reg(PTR_CFG_WR, 8'h40);
    wait_idle();
    n_start = 0;
    repeat (300) @(posedge clk);
    chk_num("starts_stopped", 0, n_start);
    for (i = 0; i < 6; i++) begin
      adj = (i == 5) ? 8'($urandom) : adj_tab[i];
      off = {8'($urandom), 4'($urandom), 4'h0};
      code_loc <= {12'($urandom), 4'h0};
      code_rem <= {12'($urandom), 4'h0};
      lat <= 8'($urandom_range(1, 60));
      wr_reg(PTR_IDEAL, adj);
      wr_reg(PTR_OFFS_HI, off[15:8]);
      wr_reg(PTR_OFFS_LO, off[7:0]);
      rd_chk("ideal_rw", PTR_IDEAL, adj);
      n_start = 0;
      n_rem = 0;
      wr_reg(PTR_ONESHOT, 8'($urandom));
      rd_chk("busy_on", PTR_STATUS, 8'h80);
      wait_idle();
      chk_num("starts_one_shot", 2, n_start);
      chk_num("remote_starts", 1, n_rem);
      er = exp_rem(int'(code_rem), adj, off);
      rd_chk("loc_hi", PTR_LOC_HI, code_loc[15:8]);
      rd_chk("loc_lo", PTR_LOC_LO, code_loc[7:0]);
      rd_chk("rem_hi", PTR_REM_HI, er[15:8]);
      rd_chk("rem_lo", PTR_REM_LO, er[7:0] & LO_MASK);
      rd_chk("ideal_kept", PTR_IDEAL, adj);
      rd_chk("cfg_kept", PTR_CFG_RD, 8'h40);
      repeat (300) @(posedge clk);
      chk_num("starts_after", 2, n_start);
    end
    // long latency keeps the second start of a sequence out of the window
    lat <= 8'd60;
    wr_reg(PTR_CFG_WR, 8'h00);
    wait (busy === 1'b1);
    wait (busy === 1'b0);
    wr_reg(PTR_ONESHOT, 8'($urandom));
    n_start = 0;
    repeat (200) @(posedge clk);
    chk_num("starts_in_gap", 0, n_start);
    repeat (100) @(posedge clk);
    chk_num("starts_resumed", 1, n_start);
    wr_reg(PTR_CFG_WR, 8'h40);
    wait_idle();
    gen_call(8'h07);
    rd_chk("ideal_other_gc", PTR_IDEAL, adj);
    rd_chk("cfg_other_gc", PTR_CFG_RD, 8'h40);
    lat <= 8'd60;
    wr_reg(PTR_ONESHOT, 8'h00);
    repeat (4) @(posedge clk);
    gen_call(GC_RESET_CMD);
    repeat (2) @(posedge clk);
    chk_num("aborts", 1, n_abort);
    rd_chk("ideal_sr", PTR_IDEAL, 8'h00);
    rd_chk("offs_sr", PTR_OFFS_HI, 8'h00);
    rd_chk("cfg_sr", PTR_CFG_RD, 8'h00);
    rd_chk("rem_sr", PTR_REM_HI, 8'h00);
    rd_chk("loc_sr", PTR_LOC_HI, 8'h00);
    give_verdict();
  end
endmodule
